// file: hdl/jesd_lane_status_flags.sv
// Lane 3 and lane 4 health flag registers with paged links behind AXI4-Lite
//
// Design decision made here: the AXI4-Lite slave port.
`include "jesd_lane_status_regs.svh"

module jesd_lane_status_flags #(
    parameter int NUM_LINKS = 2,
    parameter int CW        = 8
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Receiver events: per link, lane3 kinds 0..2 then lane4 kinds 0..2
    input  wire logic [NUM_LINKS*6-1:0]   errEvent,
    // Lane 3 sync levels per link: deskew, align, checksum, frame, code group
    input  wire logic [NUM_LINKS*5-1:0]   lane3Sync,
    // AXI4-Lite write address
    input  wire logic [15:0]              awaddr,
    input  wire logic                     awvalid,
    output logic                          awready,
    // AXI4-Lite write data
    input  wire logic [31:0]              wdata,
    input  wire logic [3:0]               wstrb,
    input  wire logic                     wvalid,
    output logic                          wready,
    // AXI4-Lite write response
    output logic [1:0]                    bresp,
    output logic                          bvalid,
    input  wire logic                     bready,
    // AXI4-Lite read address
    input  wire logic [15:0]              araddr,
    input  wire logic                     arvalid,
    output logic                          arready,
    // AXI4-Lite read data
    output logic [31:0]                   rdata,
    output logic [1:0]                    rresp,
    output logic                          rvalid,
    input  wire logic                     rready,
    // Interrupt
    output logic                          irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [15:0]            awAddrQ;       // Held write address
    logic                   awHeld;        // Write address taken
    logic [31:0]            wDataQ;        // Held write data
    logic [3:0]             wStrbQ;        // Held byte enables
    logic                   wHeld;         // Write data taken
    logic                   doWrite;       // Both halves present
    logic                   doRead;        // Read address handshake
    logic [7:0]             linkPage;      // Selected link
    logic [CW-1:0]          threshold;     // Error threshold
    logic [2:0]             irqStatus;     // Sticky events
    logic [2:0]             irqMask;       // Event enables
    logic                   countClear;    // One-cycle counter clear
    logic [NUM_LINKS*6-1:0] errFlag;       // Per counter threshold flag
    logic [NUM_LINKS*6-1:0] errFlagPrev;   // For rising detection
    logic [NUM_LINKS*5-1:0] syncQ;         // Registered sync levels
    logic [NUM_LINKS*5-1:0] syncPrev;      // For falling detection
    logic [2:0]             irqSet;        // Events this cycle
    logic [7:0]             lane3Sel;      // Lane 3 view of selected link
    logic [7:0]             lane4Sel;      // Lane 4 view of selected link
    logic                   pageOk;        // Page names an existing link
    logic [31:0]            next_rdata;    // Read mux result
    logic                   next_rdOk;     // Read address mapped

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte address to register index
    function automatic logic [11:0] regIndex(input logic [15:0] addr);
        regIndex = addr[13:2];
    endfunction

    // Position of one counter in the flat vectors
    function automatic int flagPos(input int link, input int lane, input int kind);
        flagPos = link * 6 + lane * 3 + kind;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Error counters, one per link, lane and kind
    for (genvar g = 0; g < NUM_LINKS * 6; g++) begin : gCnt
        err_counter #(
            .CW (CW)
        ) uCnt (
            .clk         (clk),
            .rst         (rst),
            .clear       (countClear),
            .errEvent    (errEvent[g]),
            .threshold   (threshold),
            .count       (),
            .atThreshold (errFlag[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync levels come from receiver logic on this clock; one stage for edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncQ       <= '0;
            syncPrev    <= '0;
            errFlagPrev <= '0;
        end else begin
            syncQ       <= lane3Sync;
            syncPrev    <= syncQ;
            errFlagPrev <= errFlag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Paged views; a page beyond the last link reads as zero
    always_comb begin
        lane3Sel = `RST_HEALTH;
        lane4Sel = `RST_HEALTH;
        pageOk   = (linkPage < NUM_LINKS[7:0]);
        for (int l = 0; l < NUM_LINKS; l++) begin
            if (linkPage == l[7:0]) begin
                lane3Sel[`BIT_DISPARITY_ERR] =
                    errFlag[flagPos(l, 0, jesd_lane_status_pkg::ERR_DISPARITY)];
                lane3Sel[`BIT_BAD_SYMBOL] =
                    errFlag[flagPos(l, 0, jesd_lane_status_pkg::ERR_BAD_SYMBOL)];
                lane3Sel[`BIT_STRAY_CONTROL] =
                    errFlag[flagPos(l, 0, jesd_lane_status_pkg::ERR_STRAY_CONTROL)];
                lane3Sel[`BIT_DESKEW_OK]     = syncQ[l*5+4];
                lane3Sel[`BIT_INITIAL_ALIGN] = syncQ[l*5+3];
                lane3Sel[`BIT_CONFIG_SUM]    = syncQ[l*5+2];
                lane3Sel[`BIT_FRAME_ALIGN]   = syncQ[l*5+1];
                lane3Sel[`BIT_CODE_GROUP]    = syncQ[l*5+0];
                lane4Sel[`BIT_DISPARITY_ERR] =
                    errFlag[flagPos(l, 1, jesd_lane_status_pkg::ERR_DISPARITY)];
                lane4Sel[`BIT_BAD_SYMBOL] =
                    errFlag[flagPos(l, 1, jesd_lane_status_pkg::ERR_BAD_SYMBOL)];
                lane4Sel[`BIT_STRAY_CONTROL] =
                    errFlag[flagPos(l, 1, jesd_lane_status_pkg::ERR_STRAY_CONTROL)];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt events: any link raising an error flag, or losing lane 3 sync
    always_comb begin
        irqSet = 3'h0;
        for (int l = 0; l < NUM_LINKS; l++) begin
            for (int k = 0; k < 3; k++) begin
                if (errFlag[flagPos(l, 0, k)] && !errFlagPrev[flagPos(l, 0, k)]) begin
                    irqSet[`IRQ_LANE3_ERR] = 1'b1;
                end
                if (errFlag[flagPos(l, 1, k)] && !errFlagPrev[flagPos(l, 1, k)]) begin
                    irqSet[`IRQ_LANE4_ERR] = 1'b1;
                end
            end
        end
        if ((syncPrev & ~syncQ) != '0) begin
            irqSet[`IRQ_LANE3_SYNC_LOST] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; status registers are read only
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rdOk  = 1'b1;
        unique case (regIndex(araddr))
            `IDX_LINK_PAGE:     next_rdata = {24'h00_0000, linkPage};
            `IDX_ERR_THRESHOLD: next_rdata = {{(32-CW){1'b0}}, threshold};
            `IDX_IRQ_STATUS:    next_rdata = {29'h0000_0000, irqStatus};
            `IDX_IRQ_MASK:      next_rdata = {29'h0000_0000, irqMask};
            `IDX_COUNT_CLEAR:   next_rdata = 32'h0000_0000;
            `IDX_LANE3_HEALTH:  next_rdata = {24'h00_0000, lane3Sel};
            `IDX_LANE4_HEALTH:  next_rdata = {24'h00_0000, lane4Sel};
            default:            next_rdOk  = 1'b0;
        endcase
    end

    assign doWrite = awHeld && wHeld && !bvalid;
    assign doRead  = arvalid && arready;

    ////////////////////////////////////////////////////////////////////////////
    // Write address channel; ready drops while an address is held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awready <= 1'b0;
            awHeld  <= 1'b0;
            awAddrQ <= 16'h0000;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            awHeld  <= 1'b1;
            awAddrQ <= awaddr;
        end else if (doWrite) begin
            awHeld  <= 1'b0;
        end else if (!awHeld && !bvalid) begin
            awready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write data channel, taken independently of the address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wready <= 1'b0;
            wHeld  <= 1'b0;
            wDataQ <= 32'h0000_0000;
            wStrbQ <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            wHeld  <= 1'b1;
            wDataQ <= wdata;
            wStrbQ <= wstrb;
        end else if (doWrite) begin
            wHeld  <= 1'b0;
        end else if (!wHeld && !bvalid) begin
            wready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write response; unmapped addresses answer with a slave error
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= jesd_lane_status_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            unique case (regIndex(awAddrQ))
                `IDX_LINK_PAGE, `IDX_ERR_THRESHOLD, `IDX_IRQ_STATUS, `IDX_IRQ_MASK,
                `IDX_COUNT_CLEAR, `IDX_LANE3_HEALTH, `IDX_LANE4_HEALTH:
                    bresp <= jesd_lane_status_pkg::RESP_OKAY;
                default:
                    bresp <= jesd_lane_status_pkg::RESP_SLVERR;
            endcase
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers; only byte lane 0 carries data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            linkPage   <= `RST_LINK_PAGE;
            threshold  <= CW'(`RST_THRESHOLD);
            irqMask    <= `RST_IRQ_MASK;
            countClear <= 1'b0;
        end else begin
            countClear <= 1'b0;
            if (doWrite && wStrbQ[0]) begin
                unique case (regIndex(awAddrQ))
                    `IDX_LINK_PAGE:     linkPage   <= wDataQ[7:0];
                    `IDX_ERR_THRESHOLD: threshold  <= wDataQ[CW-1:0];
                    `IDX_IRQ_MASK:      irqMask    <= wDataQ[2:0];
                    `IDX_COUNT_CLEAR:   countClear <= wDataQ[0];
                    default:            countClear <= 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel; data registered one cycle after the address is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= jesd_lane_status_pkg::RESP_OKAY;
        end else if (doRead) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= next_rdata;
            rresp   <= next_rdOk ? jesd_lane_status_pkg::RESP_OKAY
                                 : jesd_lane_status_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
        end else if (!rvalid && !arready) begin
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status; read clears, a new event in that cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStatus <= 3'h0;
        end else if (doRead && (regIndex(araddr) == `IDX_IRQ_STATUS)) begin
            irqStatus <= irqSet;
        end else begin
            irqStatus <= irqStatus | irqSet;
        end
    end

    // Interrupt level from the registered status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= ((irqStatus & irqMask) != 3'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    lane3_disparity_a: assert property (@(posedge clk) disable iff (rst)
        doRead && regIndex(araddr) == `IDX_LANE3_HEALTH
        |=> rdata[`BIT_DISPARITY_ERR] == $past(lane3Sel[`BIT_DISPARITY_ERR]) && rvalid)
        else $error("lane 3 disparity flag misread");

    lane3_symbol_a: assert property (@(posedge clk) disable iff (rst)
        doRead && regIndex(araddr) == `IDX_LANE3_HEALTH && linkPage == 8'h00
        |=> rdata[`BIT_BAD_SYMBOL] == $past(errFlag[1]))
        else $error("lane 3 bad symbol flag misread");

    lane3_control_a: assert property (@(posedge clk) disable iff (rst)
        doRead && regIndex(araddr) == `IDX_LANE3_HEALTH && linkPage == 8'h00
        |=> rdata[`BIT_STRAY_CONTROL] == $past(errFlag[2]))
        else $error("lane 3 stray control flag misread");

    lane3_sync_a: assert property (@(posedge clk) disable iff (rst)
        doRead && regIndex(araddr) == `IDX_LANE3_HEALTH && linkPage == 8'h00
        |=> rdata[4:0] == $past(lane3Sync[4:0], 2))
        else $error("lane 3 sync bits misread");

    page_range_a: assert property (@(posedge clk) disable iff (rst)
        !pageOk |-> (lane3Sel == 8'h00) && (lane4Sel == 8'h00))
        else $error("page beyond last link returned data");

    lane4_disparity_a: assert property (@(posedge clk) disable iff (rst)
        doRead && regIndex(araddr) == `IDX_LANE4_HEALTH && linkPage == 8'h00
        |=> rdata[7:5] == {$past(errFlag[3]), $past(errFlag[4]), $past(errFlag[5])})
        else $error("lane 4 error flags misread");

    lane4_upper_a: assert property (@(posedge clk) disable iff (rst)
        doRead && regIndex(araddr) == `IDX_LANE4_HEALTH |=> rdata[31:8] == 24'h00_0000)
        else $error("lane 4 upper bits not zero");

    status_ro_a: assert property (@(posedge clk) disable iff (rst)
        doWrite && regIndex(awAddrQ) == `IDX_LANE3_HEALTH |=> !countClear
        && $stable(threshold) && $stable(linkPage))
        else $error("write to read-only status changed state");

    resp_order_a: assert property (@(posedge clk) disable iff (rst)
        doWrite |=> bvalid && !awHeld && !wHeld)
        else $error("write response not raised after both halves");

endmodule

// file: hdl/jesd_lane_status_regs.svh
// Register indices, field positions, reset values and counter saturation value of the lane status block
`ifndef JESD_LANE_STATUS_REGS_SVH
`define JESD_LANE_STATUS_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_LINK_PAGE        12'h300
`define IDX_ERR_THRESHOLD    12'h310
`define IDX_IRQ_STATUS       12'h311
`define IDX_IRQ_MASK         12'h312
`define IDX_COUNT_CLEAR      12'h313
`define IDX_LANE3_HEALTH     12'h4B3
`define IDX_LANE4_HEALTH     12'h4B4

// Lane health field positions
`define BIT_DISPARITY_ERR    7
`define BIT_BAD_SYMBOL       6
`define BIT_STRAY_CONTROL    5
`define BIT_DESKEW_OK        4
`define BIT_INITIAL_ALIGN    3
`define BIT_CONFIG_SUM       2
`define BIT_FRAME_ALIGN      1
`define BIT_CODE_GROUP       0

// Interrupt status field positions
`define IRQ_LANE3_ERR        0
`define IRQ_LANE4_ERR        1
`define IRQ_LANE3_SYNC_LOST  2

// Reset values
`define RST_HEALTH           8'h00
`define RST_THRESHOLD        8'hFF
`define RST_IRQ_MASK         3'h0
`define RST_LINK_PAGE        8'h00

// Counter saturation value
`define COUNT_MAX            8'hFF

`endif

// file: hdl/jesd_lane_status_pkg.sv
// Types shared by the lane status block
package jesd_lane_status_pkg;

    // Error kinds counted per lane
    typedef enum logic [1:0] {
        ERR_DISPARITY = 2'b00,
        ERR_BAD_SYMBOL = 2'b01,
        ERR_STRAY_CONTROL = 2'b10
    } err_kind_t;

    // Bus responses
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

endpackage

// file: hdl/err_counter.sv
// Saturating error counter with continuous threshold comparison
module err_counter #(
    parameter int CW = 8
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Control
    input  wire logic          clear,
    input  wire logic          errEvent,
    input  wire logic [CW-1:0] threshold,
    // Result
    output logic      [CW-1:0] count,
    output logic               atThreshold
);

    ////////////////////////////////////////////////////////////////////////////
    // Counting; saturates so a long error burst never wraps the flag off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (errEvent && (count != {CW{1'b1}})) begin
            count <= count + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare against threshold every cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            atThreshold <= 1'b0;
        end else begin
            atThreshold <= (count >= threshold);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    count_sat_a: assert property (@(posedge clk) disable iff (rst)
        (count == {CW{1'b1}}) && !clear |=> (count == {CW{1'b1}}))
        else $error("error counter wrapped past saturation");

endmodule

// file: tb/lane_link_model.sv
// Far-side link model: error pulses and lane 3 sync levels per link
module lane_link_model #(
    parameter int NUM_LINKS = 2
) (
    // Clock
    input  wire logic                 clk,
    // Receiver observations
    output logic [NUM_LINKS*6-1:0]    errEvent,
    output logic [NUM_LINKS*5-1:0]    lane3Sync
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet link, nothing locked
    initial begin
        errEvent <= '0;
        lane3Sync <= '0;
    end

    // Back-to-back errors on one bit; extra edges let flag and irq settle
    task automatic sendErrors(input int idx, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            errEvent[idx] <= 1'b1;
        end
        @(posedge clk);
        errEvent[idx] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // New sync levels, then time for the registered copy
    task automatic setSync(input logic [NUM_LINKS*5-1:0] v);
        @(posedge clk);
        lane3Sync <= v;
        repeat (3) @(posedge clk);
    endtask
endmodule

// file: tb/tb_jesd_lane_status_flags.sv
// Self-checking bench for the lane health flag block
`include "jesd_lane_status_regs.svh"
module tb_jesd_lane_status_flags;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK  = jesd_lane_status_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = jesd_lane_status_pkg::RESP_SLVERR;
    ////////////////////////////////////////////////////////////////////////
    // Clock, reset, bus and link signals
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] awaddr = '0;
    logic [15:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic [3:0]  wstrb = '0;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] errEvent;
    logic [9:0]  lane3Sync;
    int          mismatches = 0;
    int          n_tests = 0;

    // 25 MHz
    always #20 clk = ~clk;

    jesd_lane_status_flags #(.NUM_LINKS(2), .CW(8)) dut_u (
        .clk(clk), .rst(rst), .errEvent(errEvent), .lane3Sync(lane3Sync),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));

    lane_link_model #(.NUM_LINKS(2)) link_u (
        .clk(clk), .errEvent(errEvent), .lane3Sync(lane3Sync));
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One comparison, logged on mismatch
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // A bus wait ran out: count it and stop
    task automatic hang(input string what);
        mismatches++;
        $display("Error at %0t ns: %s timed out", $time, what);
        complete_run();
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Write: address and data offered together, each dropped when taken
    task automatic axiWrite(input logic [11:0] idx, input logic [7:0] val,
                            input logic [3:0] strb, input logic [1:0] exp);
        int k;
        k = 0;
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, val};
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (k < 50) begin
            @(posedge clk);
            k++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                check({30'h0, bresp}, {30'h0, exp}, "write response");
                k = 99;
            end
        end
        // One idle edge so the next call never re-drives bready in this step
        @(posedge clk);
        if (k != 99) hang("write");
    endtask

    // Read one register and compare data and response
    task automatic rdChk(input logic [11:0] idx, input logic [31:0] exp,
                         input logic [1:0] er, input string what);
        int k;
        k = 0;
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (k < 50) begin
            @(posedge clk);
            k++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                check(rdata, exp, what);
                check({30'h0, rresp}, {30'h0, er}, "read response");
                k = 99;
            end
        end
        // One idle edge so the next call never re-drives rready in this step
        @(posedge clk);
        if (k != 99) hang("read");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset values, unmapped place, writes to read-only health
    task automatic resetScan();
        rdChk(`IDX_LANE3_HEALTH, 32'h00, OK, "lane3 reset");
        rdChk(`IDX_LANE4_HEALTH, 32'h00, OK, "lane4 reset");
        rdChk(`IDX_ERR_THRESHOLD, 32'hFF, OK, "threshold reset");
        rdChk(`IDX_IRQ_MASK, 32'h00, OK, "mask reset");
        rdChk(12'h0FF, 32'h00, ERR, "unmapped read");
        axiWrite(12'h0FF, 8'h12, 4'hF, ERR);
        axiWrite(`IDX_LANE3_HEALTH, 8'hFF, 4'hF, OK);
        rdChk(`IDX_LANE3_HEALTH, 32'h00, OK, "health written");
    endtask

    // Each lane and kind of link 0: one below threshold, then exactly at it
    task automatic errScan();
        logic [11:0] r;
        axiWrite(`IDX_ERR_THRESHOLD, 8'h03, 4'hF, OK);
        for (int n = 0; n < 6; n++) begin
            r = (n < 3) ? `IDX_LANE3_HEALTH : `IDX_LANE4_HEALTH;
            axiWrite(`IDX_COUNT_CLEAR, 8'h01, 4'hF, OK);
            link_u.sendErrors(n, 2);
            rdChk(r, 32'h00, OK, "below threshold");
            link_u.sendErrors(n, 1);
            rdChk(r, 32'h80 >> (n % 3), OK, "at threshold");
        end
        check({31'h0, irq}, 32'h0, "masked irq");
        // Long burst past full scale: a wrapping counter would drop the flag
        axiWrite(`IDX_ERR_THRESHOLD, 8'hFF, 4'hF, OK);
        axiWrite(`IDX_COUNT_CLEAR, 8'h01, 4'hF, OK);
        link_u.sendErrors(0, 300);
        rdChk(`IDX_LANE3_HEALTH, 32'h80, OK, "saturated count");
        axiWrite(`IDX_ERR_THRESHOLD, 8'h03, 4'hF, OK);
    endtask

    // Walk one sync bit across lane 3; lane 4 has none
    task automatic syncScan();
        axiWrite(`IDX_COUNT_CLEAR, 8'h01, 4'hF, OK);
        for (int b = 0; b < 5; b++) begin
            link_u.setSync(10'h1 << b);
            rdChk(`IDX_LANE3_HEALTH, 32'h1 << b, OK, "sync bit");
        end
        rdChk(`IDX_LANE4_HEALTH, 32'h00, OK, "lane4 low bits");
    endtask

    // Two links differ; page picks one, strobe off leaves page alone
    task automatic pageScan();
        link_u.setSync({5'h0A, 5'h15});
        link_u.sendErrors(6, 3);
        rdChk(`IDX_LANE3_HEALTH, 32'h15, OK, "page 0");
        axiWrite(`IDX_LINK_PAGE, 8'h01, 4'hF, OK);
        rdChk(`IDX_LANE3_HEALTH, 32'h8A, OK, "page 1");
        axiWrite(`IDX_LINK_PAGE, 8'h02, 4'h0, OK);
        rdChk(`IDX_LINK_PAGE, 32'h01, OK, "strobe off");
        axiWrite(`IDX_LINK_PAGE, 8'h02, 4'hF, OK);
        rdChk(`IDX_LANE3_HEALTH, 32'h00, OK, "page beyond links");
        axiWrite(`IDX_LINK_PAGE, 8'h00, 4'hF, OK);
    endtask

    // Latched events, read clear, unmasked level output
    task automatic irqScan();
        rdChk(`IDX_IRQ_STATUS, 32'h07, OK, "events latched");
        rdChk(`IDX_IRQ_STATUS, 32'h00, OK, "read clears");
        axiWrite(`IDX_IRQ_MASK, 8'h01, 4'hF, OK);
        axiWrite(`IDX_COUNT_CLEAR, 8'h01, 4'hF, OK);
        check({31'h0, irq}, 32'h0, "irq before event");
        link_u.sendErrors(0, 3);
        check({31'h0, irq}, 32'h1, "irq raised");
        rdChk(`IDX_IRQ_STATUS, 32'h01, OK, "lane3 event");
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0, "irq cleared");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        resetScan();
        errScan();
        syncScan();
        pageScan();
        irqScan();
        complete_run();
    end
endmodule
